// ---- verilog/telemetry_bank_defs.vh ----
// Offsets, field positions, reset values and timing counts of the telemetry readback bank
`ifndef TELEMETRY_BANK_DEFS_VH
`define TELEMETRY_BANK_DEFS_VH

`define OFS_NTC_READING 8'h40
`define OFS_SERIES_RES 8'h41
`define OFS_CHEM_CELLS 8'h43
`define OFS_ICHG_SETPOINT 8'h44
`define OFS_VCHG_SETPOINT 8'h45
`define OFS_INLIM_SETPOINT 8'h46
`define OFS_VBAT_FILT 8'h47
`define OFS_RES_TEST_CUR 8'h48
`define OFS_MEAS_STATUS 8'h4a
`define OFS_FLOOR_SETPOINT 8'h4b

`define CHEM_MSB 11
`define CHEM_LSB 8
`define STAT_LOW_SIGNAL 1
`define STAT_VALID 0

`define NTC_OPEN_CODE 16'h54b4
`define NTC_FULL_SCALE 16'h5545
`define BSR_DIVISOR 16'h00fa
`define TENTH_CURRENT_CODE 16'h0888
`define CELLS_UNKNOWN 4'h0

`define RESET_WORD 16'h0000
`define WARMUP_TIME_MS 12
`define CLOCK_KHZ 100000
`define WARMUP_CYCLES (`WARMUP_TIME_MS * `CLOCK_KHZ)
`define SOFT_STEP_CYCLES 16'h0064
`define FILTER_SHIFT 3

`endif

// ---- verilog/setpoint_ramp.v ----
// Soft-start and soft-stop stepper for the charge current set-point
`timescale 1ns/1ps
`include "telemetry_bank_defs.vh"

module setpoint_ramp (
    // Clock and reset
    input wire clock,
    input wire rst_n,
    // Target and result
    input wire [4:0] target,
    output reg [4:0] value
);
    reg [15:0] tick;

    // One code per step interval, so current never jumps
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tick <= 16'h0000;
            value <= 5'h00;
        end else if (tick == `SOFT_STEP_CYCLES - 16'h0001) begin
            tick <= 16'h0000;
            if (value < target) begin
                value <= value + 5'h01;
            end else if (value > target) begin
                value <= value - 5'h01;
            end
        end else begin
            tick <= tick + 16'h0001;
        end
    end
endmodule

// ---- verilog/charger_telemetry_readback_bank.v ----
// Read-only telemetry and live set-point register bank of the charger
`timescale 1ns/1ps
`include "telemetry_bank_defs.vh"

module charger_telemetry_readback_bank #(
    parameter WARMUP_CYCLES = `WARMUP_CYCLES,
    // Variant code value is arbitrary
    parameter [3:0] CHEMISTRY_CODE = 4'h5
) (
    // Clock and reset
    input wire clock,
    input wire rst_n,
    // Register port from the serial management interface
    input wire [7:0] reg_addr,
    input wire reg_read,
    input wire reg_write,
    input wire [15:0] reg_wdata,
    output reg [15:0] reg_rdata,
    // Cell select straps, asynchronous pins
    input wire cell_select_pin_a,
    input wire cell_select_pin_b,
    // Charger state
    input wire charger_enabled,
    input wire [2:0] charge_phase,
    // Measurement results from the converter
    input wire meas_strobe,
    input wire [15:0] ntc_sample,
    input wire [15:0] vbat_sample,
    input wire bsr_strobe,
    input wire [15:0] bsr_sample,
    input wire [15:0] ibat_sample,
    // Programmed settings from the configuration bank
    input wire [5:0] vcharge_setting,
    input wire [5:0] absorb_delta,
    input wire [5:0] equalize_delta,
    input wire temp_comp_enable,
    input wire [5:0] iin_limit_target,
    input wire [4:0] charge_current_setting,
    input wire mppt_enable,
    input wire [7:0] mppt_floor,
    input wire [7:0] input_floor_setting,
    // Outputs to the charge logic
    output wire charge_inhibit,
    output wire [4:0] charge_current_dac,
    output reg [5:0] charge_voltage_dac,
    output reg [5:0] input_limit_dac,
    output reg [7:0] input_floor_dac,
    output wire ntc_open
);
    localparam PH_OFF = 3'd0;
    localparam PH_BULK = 3'd1;
    localparam PH_ABSORB = 3'd2;
    localparam PH_FLOAT = 3'd3;
    localparam PH_EQUALIZE = 3'd4;

    reg sel_a_meta;
    reg sel_a;
    reg sel_b_meta;
    reg sel_b;
    reg en_meta;
    reg en_sync;
    reg [15:0] ntc_reading;
    reg [15:0] series_resistance_result;
    reg [15:0] filtered_battery_voltage;
    reg [15:0] resistance_test_current;
    reg low_signal;
    reg telemetry_valid;
    reg [31:0] warm_count;
    reg [4:0] next_current_target;
    reg [6:0] next_voltage;
    wire [3:0] cell_count;
    wire [17:0] filt_sum;
    wire signed [17:0] filt_old;
    wire signed [17:0] filt_in;
    wire warm_done;
    reg [15:0] status_word;
    reg [15:0] chem_word;
    reg [15:0] next_rdata;

    function [6:0] add_sat;
        input [6:0] base;
        input [5:0] delta;
        reg [7:0] sum;
        begin
            sum = {1'b0, base} + {2'b00, delta};
            add_sat = (sum > 8'h3f) ? 7'h3f : sum[6:0];
        end
    endfunction

    // Two codes per six-volt group
    function [3:0] cells_from_straps;
        input strap_b;
        input strap_a;
        begin
            case ({strap_b, strap_a})
                2'b00: cells_from_straps = 4'h2;
                2'b01: cells_from_straps = 4'h4;
                2'b10: cells_from_straps = 4'h6;
                default: cells_from_straps = 4'h8;
            endcase
        end
    endfunction

    // Float holds half the programmed current; bulk, absorb and equalize carry all of it; off and unused codes carry none
    function [4:0] phase_current;
        input [2:0] phase;
        input [4:0] setting;
        begin
            case (phase)
                PH_BULK: phase_current = setting;
                PH_ABSORB: phase_current = setting;
                PH_EQUALIZE: phase_current = setting;
                PH_FLOAT: phase_current = {1'b0, setting[4:1]};
                default: phase_current = 5'h00;
            endcase
        end
    endfunction

    // Absorb adds its offset; equalize adds both offsets
    function [6:0] phase_voltage;
        input [2:0] phase;
        input [5:0] setting;
        input [5:0] absorb;
        input [5:0] equalize;
        begin
            case (phase)
                PH_ABSORB: phase_voltage = add_sat({1'b0, setting}, absorb);
                PH_EQUALIZE: phase_voltage = add_sat(add_sat({1'b0, setting}, absorb), equalize);
                default: phase_voltage = {1'b0, setting};
            endcase
        end
    endfunction

    // Narrow set-points sit in the low bits of a zeroed word
    function [15:0] low_field;
        input [7:0] field;
        begin
            low_field = {8'h00, field};
        end
    endfunction

    // Strap and enable pins cross into the clock domain
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sel_a_meta <= 1'b0;
            sel_a <= 1'b0;
        end else begin
            sel_a_meta <= cell_select_pin_a;
            sel_a <= sel_a_meta;
        end
    end

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sel_b_meta <= 1'b0;
            sel_b <= 1'b0;
        end else begin
            sel_b_meta <= cell_select_pin_b;
            sel_b <= sel_b_meta;
        end
    end

    // Enable drop must reach the timer even in mid-charge
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            en_meta <= 1'b0;
            en_sync <= 1'b0;
        end else begin
            en_meta <= charger_enabled;
            en_sync <= en_meta;
        end
    end

    assign cell_count = en_sync ? cells_from_straps(sel_b, sel_a) : `CELLS_UNKNOWN;

    // Warm-up timer restarts whenever the charger drops out
    assign warm_done = (warm_count >= WARMUP_CYCLES - 1);
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            warm_count <= 32'h0000_0000;
            telemetry_valid <= 1'b0;
        end else if (!en_sync) begin
            warm_count <= 32'h0000_0000;
            telemetry_valid <= 1'b0;
        end else if (warm_done) begin
            telemetry_valid <= 1'b1;
        end else begin
            warm_count <= warm_count + 32'h0000_0001;
        end
    end

    assign charge_inhibit = !telemetry_valid;

    // Filter trades response speed for noise: first-order, 1/8 weight
    assign filt_old = {{2{filtered_battery_voltage[15]}}, filtered_battery_voltage};
    assign filt_in = {{2{vbat_sample[15]}}, vbat_sample};
    assign filt_sum = filt_old - (filt_old >>> `FILTER_SHIFT) + (filt_in >>> `FILTER_SHIFT);

    // Raw codes kept; scaling against the external resistors is left to software
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ntc_reading <= `RESET_WORD;
        end else if (meas_strobe) begin
            ntc_reading <= ntc_sample;
        end
    end

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            filtered_battery_voltage <= `RESET_WORD;
        end else if (meas_strobe) begin
            filtered_battery_voltage <= filt_sum[15:0];
        end
    end

    assign ntc_open = (ntc_reading == `NTC_OPEN_CODE);

    // Result, test current and flag share one strobe so they always pair
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            series_resistance_result <= `RESET_WORD;
        end else if (bsr_strobe) begin
            series_resistance_result <= bsr_sample;
        end
    end

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            resistance_test_current <= `RESET_WORD;
        end else if (bsr_strobe) begin
            resistance_test_current <= ibat_sample;
        end
    end

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            low_signal <= 1'b0;
        end else if (bsr_strobe) begin
            low_signal <= ($signed(ibat_sample) < $signed(`TENTH_CURRENT_CODE));
        end
    end

    // Current target per phase; no charge before warm-up
    always @* begin
        next_current_target = phase_current(charge_phase, charge_current_setting);
        if (charge_inhibit || !en_sync) begin
            next_current_target = 5'h00;
        end
    end

    setpoint_ramp current_ramp (
        .clock(clock),
        .rst_n(rst_n),
        .target(next_current_target),
        .value(charge_current_dac)
    );

    // Voltage code: phase offsets, then cold compensation from the thermistor
    always @* begin
        next_voltage = phase_voltage(charge_phase, vcharge_setting, absorb_delta,
            equalize_delta);
        // Higher reading means colder cell, which needs a higher voltage
        if (temp_comp_enable && !ntc_open && ntc_reading[15:14] == 2'b01) begin
            next_voltage = add_sat(next_voltage, 6'h02);
        end
    end

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            charge_voltage_dac <= 6'h00;
        end else begin
            charge_voltage_dac <= next_voltage[5:0];
        end
    end

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            input_limit_dac <= 6'h00;
        end else begin
            input_limit_dac <= iin_limit_target;
        end
    end

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            input_floor_dac <= 8'h00;
        end else begin
            input_floor_dac <= mppt_enable ? mppt_floor : input_floor_setting;
        end
    end

    // Status and chemistry words built field by field
    always @* begin
        status_word = `RESET_WORD;
        status_word[`STAT_LOW_SIGNAL] = low_signal;
        status_word[`STAT_VALID] = telemetry_valid;
        chem_word = `RESET_WORD;
        chem_word[`CHEM_MSB:`CHEM_LSB] = CHEMISTRY_CODE;
        chem_word[3:0] = cell_count;
    end

    // Read decode; reg_write and reg_wdata have no effect by design
    always @* begin
        case (reg_addr)
            `OFS_NTC_READING: next_rdata = ntc_reading;
            `OFS_SERIES_RES: next_rdata = series_resistance_result;
            `OFS_CHEM_CELLS: next_rdata = chem_word;
            `OFS_ICHG_SETPOINT: next_rdata = low_field({3'h0, charge_current_dac});
            `OFS_VCHG_SETPOINT: next_rdata = low_field({2'h0, charge_voltage_dac});
            `OFS_INLIM_SETPOINT: next_rdata = low_field({2'h0, input_limit_dac});
            `OFS_VBAT_FILT: next_rdata = filtered_battery_voltage;
            `OFS_RES_TEST_CUR: next_rdata = resistance_test_current;
            `OFS_MEAS_STATUS: next_rdata = status_word;
            `OFS_FLOOR_SETPOINT: next_rdata = low_field(input_floor_dac);
            default: next_rdata = `RESET_WORD;
        endcase
    end

    // Read data holds until the next read, so a write cannot disturb it
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= `RESET_WORD;
        end else if (reg_read) begin
            reg_rdata <= next_rdata;
        end
    end
endmodule

// ---- bench/telemetry_bank_props.sv ----
// Port-level properties of the telemetry readback bank
`timescale 1ns/1ps
`include "telemetry_bank_defs.vh"
module telemetry_bank_props #(
    parameter [3:0] CHEMISTRY_CODE = 4'h5
) (
    input wire clock,
    input wire rst_n,
    input wire [7:0] reg_addr,
    input wire reg_read,
    input wire reg_write,
    input wire [15:0] reg_rdata,
    input wire meas_strobe,
    input wire [15:0] ntc_sample,
    input wire charger_enabled,
    input wire charge_inhibit,
    input wire [4:0] charge_current_dac,
    input wire mppt_enable,
    input wire [7:0] mppt_floor,
    input wire [7:0] input_floor_setting,
    input wire [7:0] input_floor_dac,
    input wire ntc_open
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    AST_NTC_OPEN: assert property (meas_strobe |=> ntc_open == ($past(ntc_sample) == `NTC_OPEN_CODE))
        else $error("open sensor flag wrong");
    AST_WRITE_HOLD: assert property (reg_write && !reg_read |=> $stable(reg_rdata))
        else $error("write disturbed read data");
    // Five samples cover the two synchroniser stages plus the status register
    AST_INHIBIT_OFF: assert property (!charger_enabled [*5] |-> charge_inhibit)
        else $error("charging allowed while disabled");
    AST_INHIBIT_WARM: assert property ($rose(charger_enabled) |=> charge_inhibit [*8])
        else $error("warm-up cut short");
    AST_RAMP_STEP: assert property (charge_current_dac != $past(charge_current_dac) |->
        (charge_current_dac == $past(charge_current_dac) + 5'h01) ||
        (charge_current_dac + 5'h01 == $past(charge_current_dac)))
        else $error("current set-point jumped");
    AST_RAMP_HOLD: assert property ($changed(charge_current_dac) |=> $stable(charge_current_dac) [*8])
        else $error("current ramp too fast");
    AST_FLOOR_MPPT: assert property (mppt_enable |=> input_floor_dac == $past(mppt_floor))
        else $error("floor not from tracker");
    AST_FLOOR_SET: assert property (!mppt_enable |=> input_floor_dac == $past(input_floor_setting))
        else $error("floor not from setting");
    AST_CHEM_FIELD: assert property (reg_read && reg_addr == `OFS_CHEM_CELLS |=>
        reg_rdata[15:8] == {4'h0, CHEMISTRY_CODE} && reg_rdata[7:4] == 4'h0)
        else $error("chemistry field wrong");
    cover property ($fell(charge_inhibit));
    cover property ($rose(ntc_open));
    cover property ($changed(charge_current_dac));
endmodule

bind charger_telemetry_readback_bank telemetry_bank_props #(.CHEMISTRY_CODE(CHEMISTRY_CODE)) props (
    .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_read(reg_read),
    .reg_write(reg_write), .reg_rdata(reg_rdata), .meas_strobe(meas_strobe),
    .ntc_sample(ntc_sample), .charger_enabled(charger_enabled), .charge_inhibit(charge_inhibit),
    .charge_current_dac(charge_current_dac), .mppt_enable(mppt_enable), .mppt_floor(mppt_floor),
    .input_floor_setting(input_floor_setting), .input_floor_dac(input_floor_dac),
    .ntc_open(ntc_open));

// ---- bench/mgmt_host.sv ----
// Management-port host model issuing single-word register cycles
`timescale 1ns/1ps
module mgmt_host (
    input wire clock,
    input wire [15:0] reg_rdata,
    output logic [7:0] reg_addr = 8'h00,
    output logic reg_read = 1'b0,
    output logic reg_write = 1'b0,
    output logic [15:0] reg_wdata = 16'h0000
);
    // Released read address and write data show the inverse so stale values cannot pass
    task automatic read(input logic [7:0] a, output logic [15:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        reg_addr <= ~a;
        @(posedge clock);
        d = reg_rdata;
    endtask
    task automatic write(input logic [7:0] a, input logic [15:0] w);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= w;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
        reg_wdata <= ~w;
    endtask
endmodule

// ---- bench/tb_top.sv ----
// Self-checking bench for the telemetry readback bank
`timescale 1ns/1ps
module tb_top;
    localparam logic [3:0] CHEM = 4'h7; // arbitrary
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic cell_select_pin_a = 1'b0, cell_select_pin_b = 1'b1, charger_enabled = 1'b0;
    logic meas_strobe = 1'b0, bsr_strobe = 1'b0, temp_comp_enable = 1'b0, mppt_enable = 1'b0;
    logic [2:0] charge_phase = 3'h0;
    logic [15:0] ntc_sample = 16'h0000, vbat_sample = 16'h0000;
    logic [15:0] bsr_sample = 16'h0000, ibat_sample = 16'h0000;
    logic [5:0] vcharge_setting = 6'h0a, absorb_delta = 6'h02, equalize_delta = 6'h04;
    logic [5:0] iin_limit_target = 6'h00;
    logic [4:0] charge_current_setting = 5'h03;
    logic [7:0] mppt_floor = 8'h5a, input_floor_setting = 8'h21;
    wire [7:0] reg_addr, input_floor_dac;
    wire reg_read, reg_write, charge_inhibit, ntc_open;
    wire [15:0] reg_wdata, reg_rdata;
    wire [4:0] charge_current_dac;
    wire [5:0] charge_voltage_dac, input_limit_dac;
    int num_errors = 0;
    int checks_done = 0;
    always #5 clock = ~clock;
    charger_telemetry_readback_bank #(.WARMUP_CYCLES(50), .CHEMISTRY_CODE(CHEM)) dut (
        .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_read(reg_read),
        .reg_write(reg_write), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .cell_select_pin_a(cell_select_pin_a), .cell_select_pin_b(cell_select_pin_b),
        .charger_enabled(charger_enabled), .charge_phase(charge_phase),
        .meas_strobe(meas_strobe), .ntc_sample(ntc_sample), .vbat_sample(vbat_sample),
        .bsr_strobe(bsr_strobe), .bsr_sample(bsr_sample), .ibat_sample(ibat_sample),
        .vcharge_setting(vcharge_setting), .absorb_delta(absorb_delta),
        .equalize_delta(equalize_delta), .temp_comp_enable(temp_comp_enable),
        .iin_limit_target(iin_limit_target), .charge_current_setting(charge_current_setting),
        .mppt_enable(mppt_enable), .mppt_floor(mppt_floor),
        .input_floor_setting(input_floor_setting), .charge_inhibit(charge_inhibit),
        .charge_current_dac(charge_current_dac), .charge_voltage_dac(charge_voltage_dac),
        .input_limit_dac(input_limit_dac), .input_floor_dac(input_floor_dac), .ntc_open(ntc_open));
    mgmt_host host (.clock(clock), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
        .reg_read(reg_read), .reg_write(reg_write), .reg_wdata(reg_wdata));
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] exp, input string what);
        logic [15:0] d;
        host.read(a, d);
        chk(what, exp, d);
    endtask
    task automatic meas(input logic [15:0] n, input logic [15:0] v);
        @(posedge clock);
        ntc_sample <= n;
        vbat_sample <= v;
        meas_strobe <= 1'b1;
        @(posedge clock);
        meas_strobe <= 1'b0;
        // Let the captured value settle before anyone looks at the pins
        @(posedge clock);
    endtask
    task automatic t_reset_map;
        logic [15:0] e;
        for (int a = 8'h40; a <= 8'h4b; a++) begin
            // Live set-points follow their inputs from the first edge after reset
            e = (a == 8'h45) ? 16'h000a : (a == 8'h4b) ? 16'h0021 : 16'h0000;
            if (a == 8'h43)
                e = {4'h0, CHEM, 8'h00};
            rd(8'(a), e, "reset word");
        end
    endtask
    task automatic t_warmup;
        int n;
        charger_enabled <= 1'b1;
        repeat (42) @(posedge clock);
        chk("inhibit early", 16'h0001, {15'h0000, charge_inhibit});
        n = 0;
        while (charge_inhibit !== 1'b0 && n < 40) begin
            @(posedge clock);
            n++;
        end
        chk("inhibit late", 16'h0000, {15'h0000, charge_inhibit});
        // Two synchroniser edges plus 50 warm-up cycles, seen one edge late
        chk("warm-up span", 16'h000b, 16'(n));
        rd(8'h4a, 16'h0001, "valid");
        for (int s = 0; s < 4; s++) begin
            {cell_select_pin_b, cell_select_pin_a} <= 2'(s);
            repeat (4) @(posedge clock);
            rd(8'h43, {4'h0, CHEM, 4'h0, 4'(2 * (s + 1))}, "cells");
        end
    endtask
    task automatic t_ntc_filter;
        meas(16'h54b4, 16'h0800);
        rd(8'h40, 16'h54b4, "ntc");
        chk("open", 16'h0001, {15'h0000, ntc_open});
        rd(8'h47, 16'h0100, "vbat filt");
        host.write(8'h40, 16'hffff);
        rd(8'h40, 16'h54b4, "ntc after write");
        meas(16'h4000, 16'h0800);
        chk("open", 16'h0000, {15'h0000, ntc_open});
        rd(8'h47, 16'h01e0, "vbat filt");
    endtask
    task automatic t_bsr;
        for (int i = 0; i < 2; i++) begin
            @(posedge clock);
            bsr_sample <= 16'h1234 + 16'(i);
            ibat_sample <= 16'h0887 + 16'(i);
            bsr_strobe <= 1'b1;
            @(posedge clock);
            bsr_strobe <= 1'b0;
            rd(8'h41, 16'h1234 + 16'(i), "bsr");
            rd(8'h48, 16'h0887 + 16'(i), "test current");
            rd(8'h4a, {14'h0000, 1'(1 - i), 1'b1}, "status");
        end
    endtask
    task automatic t_setpoints;
        iin_limit_target <= 6'h2a;
        mppt_enable <= 1'b1;
        rd(8'h46, 16'h002a, "input limit");
        chk("limit pin", 16'h002a, {10'h000, input_limit_dac});
        rd(8'h4b, 16'h005a, "floor mppt");
        mppt_enable <= 1'b0;
        rd(8'h4b, 16'h0021, "floor setting");
    endtask
    task automatic t_ramp;
        int n;
        charge_phase <= 3'h1;
        n = 0;
        while (charge_current_dac !== 5'h03 && n < 500) begin
            @(posedge clock);
            n++;
        end
        rd(8'h44, 16'h0003, "bulk current");
        charge_phase <= 3'h3;
        repeat (250) @(posedge clock);
        rd(8'h44, 16'h0001, "float current");
        chk("current pin", 16'h0001, {11'h000, charge_current_dac});
    endtask
    task automatic t_voltage;
        charge_phase <= 3'h2;
        rd(8'h45, 16'h000c, "absorb volt");
        charge_phase <= 3'h4;
        rd(8'h45, 16'h0010, "equalize volt");
        temp_comp_enable <= 1'b1;
        rd(8'h45, 16'h0012, "cold comp volt");
        vcharge_setting <= 6'h3e;
        rd(8'h45, 16'h003f, "saturated volt");
        chk("voltage pin", 16'h003f, {10'h000, charge_voltage_dac});
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clock);
        chk("reset voltage pin", 16'h0000, {10'h000, charge_voltage_dac});
        chk("reset inhibit", 16'h0001, {15'h0000, charge_inhibit});
        rst_n <= 1'b1;
        t_reset_map();
        t_warmup();
        t_ntc_filter();
        t_bsr();
        t_setpoints();
        t_ramp();
        t_voltage();
        report_and_stop();
    end
    initial begin
        #200000;
        num_errors++;
        report_and_stop();
    end
endmodule
